// ===== verilog/gcm_general_mask.sv
`timescale 1ns/10ps
// Summary of operation
// RQ1 - enable bit low keeps interrupt pin inactive
// RQ2 - enable bit never stops event recording
// RQ3 - enable resets high; unmasked bits drive interrupt
// RQ4 - wide bit: 16-bit access, one address
// RQ5 - wide clear: two 8-bit four-channel devices
// RQ6 - priority bit picks 3-bit or 1-bit priority
// RQ7 - priority sources: 0x27/0x28 or 0x15
// RQ8 - class flag on change only when selected
// RQ9 - detect flag on change only when selected
// RQ10 - host idles shutdown input before enabling
// RQ11 - command 17h, one data byte, read/write
// RQ12 - low copy wide bit alone enables wide
// RQ13 - spare bits store value, no effect
module gcm_general_mask
  import gcm_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire gcm_req_s req,
  output gcm_rsp_s rsp_r,
  input wire logic irq_pending_lo,
  input wire logic irq_pending_hi,
  output logic irq_n_r,
  input wire logic [GCM_CHANNELS-1:0] one_bit_priority,
  input wire logic [GCM_CHANNELS*GCM_PRIO_W-1:0] three_bit_priority,
  output logic [GCM_CHANNELS*GCM_PRIO_W-1:0] channel_priority_r,
  output logic multi_bit_priority_r,
  output logic wide_access_r,
  input wire logic [GCM_CHANNELS-1:0] detect_done,
  input wire logic [GCM_CHANNELS*GCM_RESULT_W-1:0] detect_result,
  input wire logic [GCM_CHANNELS-1:0] class_done,
  input wire logic [GCM_CHANNELS*GCM_RESULT_W-1:0] class_result,
  output logic [GCM_CHANNELS-1:0] detect_event_flag_set_r,
  output logic [GCM_CHANNELS-1:0] class_event_flag_set_r
);

  ////////////////////////////////////////////////////////////////////////////
  // register copies: one for channels 1-4, one for channels 5-8
  gcm_cfg_s cfg_lo_r;
  gcm_cfg_s cfg_hi_r;
  logic wide;        // current access layout
  logic hit;         // request names this register
  logic addr_ok;     // request arrives on a served address
  logic wr_lo;       // write lands in the low copy
  logic wr_hi;       // write lands in the high copy
  logic [15:0] rd_word;

  // choose the copy that governs a channel
  function automatic gcm_cfg_s cfg_of(input gcm_cfg_s lo, input gcm_cfg_s hi, input int ch);
    cfg_of = (ch < GCM_GROUP_CH) ? lo : hi;
  endfunction

  // the low copy alone decides the layout, so one write switches the whole device
  assign wide = cfg_lo_r.wide_access_select; // RQ12
  assign hit = req.valid && (req.cmd == GCM_CMD_GENERAL_MASK); // RQ11
  // in the wide layout only the even address answers
  assign addr_ok = !wide || !req.address_lsb_pin; // RQ4
  // wide writes fill both copies from one 16-bit word; narrow ones pick by address
  assign wr_lo = hit && req.write && addr_ok && (wide || !req.address_lsb_pin); // RQ4 RQ5
  assign wr_hi = hit && req.write && addr_ok && (wide || req.address_lsb_pin); // RQ4 RQ5

  // read word: low byte is channels 1-4, high byte channels 5-8 in the wide layout
  always_comb begin
    rd_word = 16'h0000;
    if (wide) begin
      rd_word = {cfg_hi_r, cfg_lo_r}; // RQ4
    end else if (req.address_lsb_pin) begin
      rd_word = {8'h00, cfg_hi_r}; // RQ5
    end else begin
      rd_word = {8'h00, cfg_lo_r}; // RQ5
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register storage; every bit, spare ones included, reads back as written
  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_lo_r <= GCM_RESET_VALUE; // RQ3 RQ5 RQ6 RQ13
      cfg_hi_r <= GCM_RESET_VALUE; // RQ3 RQ5 RQ6 RQ13
    end else if (ce) begin
      if (wr_lo) begin
        cfg_lo_r <= req.wdata[7:0]; // RQ11 RQ13
      end
      if (wr_hi) begin
        // the high copy comes from the upper byte only in the wide layout
        cfg_hi_r <= wide ? req.wdata[15:8] : req.wdata[7:0]; // RQ11 RQ13
      end
    end
  end

  // answer one cycle after the request; a foreign command or an odd wide address gets no ack
  always_ff @(posedge clk) begin
    if (reset) begin
      rsp_r <= '0;
    end else if (ce) begin
      rsp_r.done <= req.valid;
      rsp_r.ack <= hit && addr_ok; // RQ4 RQ11
      rsp_r.rdata <= (hit && addr_ok && !req.write) ? rd_word : 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt pin, active low; each group's enable gates only that group
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_n_r <= 1'b1;
    end else if (ce) begin
      irq_n_r <= !((cfg_lo_r.irq_output_enable && irq_pending_lo) ||
                   (cfg_hi_r.irq_output_enable && irq_pending_hi)); // RQ1 RQ3
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // layout and priority mode for the rest of the device
  // a 0 to 1 change of the priority mode assumes the host has idled the
  // shutdown input first; nothing here can resynchronise the decoder otherwise
  always_ff @(posedge clk) begin
    if (reset) begin
      wide_access_r <= 1'b0;
      multi_bit_priority_r <= 1'b0;
    end else if (ce) begin
      wide_access_r <= wide; // RQ4 RQ5
      multi_bit_priority_r <= cfg_lo_r.multi_bit_priority_select; // RQ6 RQ10
    end
  end

  // per channel priority: 3-bit code, or the single bit in the lsb
  always_ff @(posedge clk) begin
    if (reset) begin
      channel_priority_r <= '0;
    end else if (ce) begin
      for (int ch = 0; ch < GCM_CHANNELS; ch++) begin
        if (cfg_of(cfg_lo_r, cfg_hi_r, ch).multi_bit_priority_select) begin
          channel_priority_r[ch*GCM_PRIO_W +: GCM_PRIO_W] <=
            three_bit_priority[ch*GCM_PRIO_W +: GCM_PRIO_W]; // RQ6 RQ7
        end else begin
          channel_priority_r[ch*GCM_PRIO_W +: GCM_PRIO_W] <=
            {2'b00, one_bit_priority[ch]}; // RQ6 RQ7
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event filtering; the interrupt enable is deliberately not an input here
  logic [GCM_CHANNELS-1:0] det_chg;
  logic [GCM_CHANNELS-1:0] cls_chg;

  // spread each copy's change-only bits over its channels
  always_comb begin
    det_chg = '0;
    cls_chg = '0;
    for (int ch = 0; ch < GCM_CHANNELS; ch++) begin
      det_chg[ch] = cfg_of(cfg_lo_r, cfg_hi_r, ch).detect_change_only; // RQ9
      cls_chg[ch] = cfg_of(cfg_lo_r, cfg_hi_r, ch).class_change_only; // RQ8
    end
  end

  // detection events, recorded whatever the interrupt enable says
  gcm_change_gate u_detect_gate (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .cycle_done(detect_done),
    .cycle_result(detect_result),
    .change_only(det_chg),
    .flag_set_r(detect_event_flag_set_r)
  ); // RQ2 RQ9

  // classification events, same treatment
  gcm_change_gate u_class_gate (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .cycle_done(class_done),
    .cycle_result(class_result),
    .change_only(cls_chg),
    .flag_set_r(class_event_flag_set_r)
  ); // RQ2 RQ8

endmodule

// ===== inc/gcm_pkg.sv
package gcm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register access
  localparam logic [7:0] GCM_CMD_GENERAL_MASK = 8'h17; // command code of the register
  localparam logic [7:0] GCM_RESET_VALUE = 8'h80;      // value after reset

  // field positions
  localparam int GCM_BIT_IRQ_EN = 7;
  localparam int GCM_BIT_SPARE6 = 6;
  localparam int GCM_BIT_WIDE = 5;
  localparam int GCM_BIT_MPRIO = 4;
  localparam int GCM_BIT_CLS_CHG = 3;
  localparam int GCM_BIT_DET_CHG = 2;
  localparam int GCM_BIT_SPARE1 = 1;
  localparam int GCM_BIT_SPARE0 = 0;

  // channel layout
  localparam int GCM_CHANNELS = 8;
  localparam int GCM_GROUP_CH = 4;  // channels served by one register copy
  localparam int GCM_RESULT_W = 4;  // width of one detect or class result
  localparam int GCM_PRIO_W = 3;    // width of one multi-bit priority code

  // idle time the host keeps on the shutdown input before enabling multi-bit priority
  localparam int GCM_SHUTDOWN_IDLE_US = 200;
  localparam int GCM_CLK_MHZ = 200;
  localparam int GCM_SHUTDOWN_IDLE_CYC = GCM_SHUTDOWN_IDLE_US * GCM_CLK_MHZ;

  ////////////////////////////////////////////////////////////////////////////
  // register layout, msb first
  typedef struct packed {
    logic irq_output_enable;
    logic spare6;
    logic wide_access_select;
    logic multi_bit_priority_select;
    logic class_change_only;
    logic detect_change_only;
    logic spare1;
    logic spare0;
  } gcm_cfg_s;

  // one register access from the serial front end
  typedef struct packed {
    logic valid;
    logic write;
    logic address_lsb_pin;
    logic [7:0] cmd;
    logic [15:0] wdata;
  } gcm_req_s;

  // answer to one register access
  typedef struct packed {
    logic done;
    logic ack;
    logic [15:0] rdata;
  } gcm_rsp_s;

endpackage

// ===== verilog/gcm_change_gate.sv
`timescale 1ns/10ps
module gcm_change_gate
  import gcm_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [GCM_CHANNELS-1:0] cycle_done,
  input wire logic [GCM_CHANNELS*GCM_RESULT_W-1:0] cycle_result,
  input wire logic [GCM_CHANNELS-1:0] change_only,
  output logic [GCM_CHANNELS-1:0] flag_set_r
);

  ////////////////////////////////////////////////////////////////////////////
  // one slice per channel: last result, and whether one has been seen yet
  genvar ch;
  generate
    for (ch = 0; ch < GCM_CHANNELS; ch = ch + 1) begin : g_ch
      logic [GCM_RESULT_W-1:0] prev_r; // result of the previous cycle
      logic seen_r;                    // a first result has been stored
      logic [GCM_RESULT_W-1:0] now_res;
      logic differs;
      logic set_r;                     // set request of this channel, one flop per slice

      assign now_res = cycle_result[ch*GCM_RESULT_W +: GCM_RESULT_W];
      // the very first result after reset counts as a change, there is nothing to compare
      assign differs = !seen_r || (now_res != prev_r);

      // remember each finished result
      always_ff @(posedge clk) begin
        if (reset) begin
          prev_r <= '0;
          seen_r <= 1'b0;
        end else if (ce && cycle_done[ch]) begin
          prev_r <= now_res;
          seen_r <= 1'b1;
        end
      end

      // set request: every cycle, or only on change when change_only is set
      // kept in a local flop so no two processes write the same output vector
      always_ff @(posedge clk) begin
        if (reset) begin
          set_r <= 1'b0;
        end else if (ce) begin
          set_r <= cycle_done[ch] && (!change_only[ch] || differs); // RQ8 RQ9
        end
      end

      assign flag_set_r[ch] = set_r;
    end
  endgenerate

endmodule

// ===== verif/gcm_general_mask_monitor.sv
`timescale 1ns/10ps
// port-level checker of the general mask register block
module gcm_general_mask_monitor
  import gcm_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire gcm_req_s req,
  input wire gcm_rsp_s rsp_r,
  input wire logic irq_pending_lo,
  input wire logic irq_pending_hi,
  input wire logic irq_n_r,
  input wire logic [GCM_CHANNELS-1:0] one_bit_priority,
  input wire logic [GCM_CHANNELS*GCM_PRIO_W-1:0] three_bit_priority,
  input wire logic [GCM_CHANNELS*GCM_PRIO_W-1:0] channel_priority_r,
  input wire logic multi_bit_priority_r,
  input wire logic wide_access_r,
  input wire logic [GCM_CHANNELS-1:0] detect_done,
  input wire logic [GCM_CHANNELS-1:0] class_done,
  input wire logic [GCM_CHANNELS-1:0] detect_event_flag_set_r,
  input wire logic [GCM_CHANNELS-1:0] class_event_flag_set_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////
  // a request taken at an enabled edge
  sequence s_take;
    ce && req.valid;
  endsequence
  // a request for this register on the low address
  sequence s_good;
    s_take ##0 req.cmd == GCM_CMD_GENERAL_MASK && !req.address_lsb_pin;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_done_on_take: assert property (s_take |=> rsp_r.done)
    else $error("no done after a request");
  a_no_req_idle: assert property (ce && !req.valid |=> !rsp_r.done)
    else $error("done without a request");
  a_low_addr_ack: assert property (s_good |=> rsp_r.ack)
    else $error("low address request not acknowledged");
  a_bad_cmd_nack: assert property (s_take ##0 req.cmd != GCM_CMD_GENERAL_MASK
    |=> !rsp_r.ack && rsp_r.rdata == 16'h0000) else $error("foreign command answered");
  a_wide_high_nack: assert property (s_take ##0 req.address_lsb_pin ##1 wide_access_r
    |-> !rsp_r.ack) else $error("high address answered in wide layout");
  a_irq_idle_high: assert property (ce && !irq_pending_lo && !irq_pending_hi |=> irq_n_r)
    else $error("interrupt pin active with nothing pending");
  a_det_no_cycle: assert property (ce && detect_done == 8'h00
    |=> detect_event_flag_set_r == 8'h00) else $error("detect flag without a cycle");
  a_cls_no_cycle: assert property (ce && class_done == 8'h00
    |=> class_event_flag_set_r == 8'h00) else $error("class flag without a cycle");
  a_prio_select: assert property (ce |=> channel_priority_r[2:0] ==
    (multi_bit_priority_r ? $past(three_bit_priority[2:0]) : {2'b00, $past(one_bit_priority[0])}))
    else $error("channel priority from wrong source");
endmodule

bind gcm_general_mask gcm_general_mask_monitor i_mon (.clk, .reset, .ce, .req, .rsp_r,
  .irq_pending_lo, .irq_pending_hi, .irq_n_r, .one_bit_priority, .three_bit_priority,
  .channel_priority_r, .multi_bit_priority_r, .wide_access_r, .detect_done, .class_done,
  .detect_event_flag_set_r, .class_event_flag_set_r);

// ===== verif/gcm_host_model.sv
`timescale 1ns/10ps
// host side of the command port, one access at a time
module gcm_host_model
  import gcm_pkg::*;
(
  input wire logic clk,
  input wire gcm_rsp_s rsp_r,
  output gcm_req_s req
);
  initial req = '0;
  // request rises after an edge, is taken at the next, answer read just after that edge
  task automatic xfer(input logic w, input logic a, input logic [7:0] c,
    input logic [15:0] d, output gcm_rsp_s r);
    @(posedge clk);
    req <= '{1'b1, w, a, c, d};
    @(posedge clk);
    // released lines show the inverse, so a stale value cannot pass as live
    req <= '{1'b0, ~w, ~a, ~c, ~d};
    #1 r = rsp_r;
  endtask
endmodule

// ===== verif/gcm_general_mask_test.sv
`timescale 1ns/10ps
module gcm_general_mask_test;
  import gcm_pkg::*;
  logic clk = 1'b0, reset = 1'b1, ce = 1'b1, irq_pending_lo = 1'b0, irq_pending_hi = 1'b0;
  logic [7:0] one_bit_priority = 8'h00, detect_done = 8'h00, class_done = 8'h00, v, c;
  logic [23:0] three_bit_priority = 24'h000000;
  logic [31:0] detect_result = 32'h00000000, class_result = 32'h00000000;
  logic [23:0] channel_priority_r;
  logic [7:0] detect_event_flag_set_r, class_event_flag_set_r;
  logic irq_n_r, multi_bit_priority_r, wide_access_r;
  gcm_req_s req;
  gcm_rsp_s rsp_r, r;
  int n_mismatch = 0, tests_run = 0, cyc = 0;
  integer seed = 32'h21ba2eb3;
  always #2.5 clk = ~clk;
  gcm_general_mask i_dut (.clk, .reset, .ce, .req, .rsp_r, .irq_pending_lo, .irq_pending_hi,
    .irq_n_r, .one_bit_priority, .three_bit_priority, .channel_priority_r,
    .multi_bit_priority_r, .wide_access_r, .detect_done, .detect_result, .class_done,
    .class_result, .detect_event_flag_set_r, .class_event_flag_set_r);
  gcm_host_model i_host (.clk, .rsp_r, .req);
  ////////////////////////////////////////////////////////////////////////////
  // expected channel priority for the selected mode
  function automatic logic [2:0] prio(logic m, logic [2:0] t, logic o);
    return m ? t : {2'b00, o};
  endfunction
  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  // single-bit results: pin, flags of the answer, mode outputs
  task chk_bit(input string n, input logic s, input logic e);
    tests_run++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %b seen %b", n, e, s);
    end
  endtask
  // both copies read back the reset value, one address each
  task chk_reset;
    for (int a = 0; a < 2; a++) begin
      i_host.xfer(1'b0, a[0], GCM_CMD_GENERAL_MASK, 16'h0000, r);
      chk("reset", r.rdata, {8'h00, GCM_RESET_VALUE});
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // one cycle end on channel 1, k picks class over detect
  task ev(input int k, input logic [3:0] x, input logic e);
    @(posedge clk);
    if (k) begin
      class_done <= 8'h01;
      class_result[3:0] <= x;
    end else begin
      detect_done <= 8'h01;
      detect_result[3:0] <= x;
    end
    @(posedge clk);
    detect_done <= 8'h00;
    class_done <= 8'h00;
    #1 chk("flag", {8'h00, (k ? class_event_flag_set_r : detect_event_flag_set_r)},
      {15'h0000, e});
  endtask
  // a hang counts as a mismatch
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      test_done;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    chk_reset;
    @(posedge clk) irq_pending_lo <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk_bit("irq", irq_n_r, 1'b0);
    i_host.xfer(1'b1, 1'b0, GCM_CMD_GENERAL_MASK, 16'h0000, r);
    @(posedge clk);
    #1 chk_bit("irq", irq_n_r, 1'b1);
    // clock enable low: the high group's pending request must wait for it
    @(posedge clk) begin
      ce <= 1'b0;
      irq_pending_hi <= 1'b1;
    end
    repeat (2) @(posedge clk);
    #1 chk_bit("irq_frozen", irq_n_r, 1'b1);
    @(posedge clk) ce <= 1'b1;
    @(posedge clk);
    #1 chk_bit("irq_hi", irq_n_r, 1'b0);
    @(posedge clk) irq_pending_hi <= 1'b0;
    // random bytes on both copies, wide bit kept clear; foreign commands between
    for (int i = 0; i < 8; i++) begin
      v = 8'($random(seed)) & 8'hDF;
      c = 8'($random(seed));
      if (c == GCM_CMD_GENERAL_MASK) c = 8'h18;
      i_host.xfer(1'b0, i[0], c, 16'h0000, r);
      chk_bit("done", r.done, 1'b1);
      chk_bit("nack", r.ack, 1'b0);
      chk("nack_rd", r.rdata, 16'h0000);
      i_host.xfer(1'b1, i[0], GCM_CMD_GENERAL_MASK, {8'h00, v}, r);
      i_host.xfer(1'b0, i[0], GCM_CMD_GENERAL_MASK, 16'h0000, r);
      chk("readback", r.rdata, {8'h00, v});
    end
    // no shutdown input reaches this block, so no idle wait is kept before bit 4
    for (int m = 0; m < 2; m++) begin
      i_host.xfer(1'b1, 1'b0, GCM_CMD_GENERAL_MASK, {11'h000, m[0], m[0], m[0], 2'b00}, r);
      @(posedge clk) begin
        one_bit_priority <= 8'($random(seed));
        three_bit_priority <= 24'($random(seed));
      end
      @(posedge clk);
      #1 chk("prio", {13'h0000, channel_priority_r[2:0]},
        {13'h0000, prio(m[0], three_bit_priority[2:0], one_bit_priority[0])});
      chk_bit("mprio", multi_bit_priority_r, m[0]);
      // channel 5 follows the high copy, which still holds the last random byte
      chk("prio_hi", {13'h0000, channel_priority_r[14:12]},
        {13'h0000, prio(v[4], three_bit_priority[14:12], one_bit_priority[4])});
      // enable bit is low here, events still recorded
      for (int k = 0; k < 2; k++) begin
        ev(k, {m[0], k[0], 2'b01}, 1'b1);
        ev(k, {m[0], k[0], 2'b01}, !m[0]);
        ev(k, {m[0], k[0], 2'b10}, 1'b1);
      end
    end
    // low copy wide bit alone switches the layout
    i_host.xfer(1'b1, 1'b0, GCM_CMD_GENERAL_MASK, 16'h0020, r);
    @(posedge clk);
    #1 chk_bit("wide", wide_access_r, 1'b1);
    v = 8'($random(seed));
    i_host.xfer(1'b1, 1'b0, GCM_CMD_GENERAL_MASK, {v, 8'h20}, r);
    i_host.xfer(1'b0, 1'b0, GCM_CMD_GENERAL_MASK, 16'h0000, r);
    chk("wide_rd", r.rdata, {v, 8'h20});
    i_host.xfer(1'b0, 1'b1, GCM_CMD_GENERAL_MASK, 16'h0000, r);
    chk_bit("wide_hi", r.ack, 1'b0);
    // reset in mid-run brings back the narrow layout and the reset byte
    @(posedge clk) reset <= 1'b1;
    @(posedge clk) reset <= 1'b0;
    chk_reset;
    chk_bit("wide_rst", wide_access_r, 1'b0);
    test_done;
  end
endmodule
